// ---- common/ilo_pkg.sv ----
// constants shared by the indexed literal offset execution logic
package ilo_pkg;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 14;
   localparam logic [7:0]  OFFSET_MAX   = 8'h5f;   // highest operand taken as an offset
   localparam logic [7:0]  FILL_VALUE   = 8'hff;
   localparam logic        EXT_RESET    = 1'b0;    // extension enable default
   // opcode upper fields
   localparam logic [3:0]  OP_SET_BIT   = 4'h8;    // 1000 bbb0
   localparam logic [7:0]  OP_FILL      = 8'h68;   // 0110 1000
   localparam logic [5:0]  OP_ADD       = 6'h09;   // 0010 01
   localparam int          BIT_SEL_LSB  = 9;
   localparam int          DEST_BIT     = 9;
   localparam int          ACCESS_BIT   = 8;
   // status vector positions
   localparam int          ST_C         = 0;
   localparam int          ST_DC        = 1;
   localparam int          ST_Z         = 2;
   localparam int          ST_OV        = 3;
   localparam int          ST_N         = 4;
   typedef enum logic [1:0] {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b10,
      Q4 = 2'b11
   } quarter_t;
   typedef enum logic [1:0] {
      OPK_NONE = 2'b00,
      OPK_ADD  = 2'b01,
      OPK_SET  = 2'b10,
      OPK_FILL = 2'b11
   } op_kind_t;
endpackage : ilo_pkg

// ---- common/data_port_if.sv ----
// data memory access signals between executer and data store
`timescale 1ns/1ps
interface data_port_if #(parameter int AW = 14, parameter int DW = 8);
   logic [AW-1:0] addr;
   logic          rd_en;
   logic          wr_en;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport master (output addr, output rd_en, output wr_en, output wdata, input rdata);
   modport slave  (input addr, input rd_en, input wr_en, input wdata, output rdata);
endinterface : data_port_if

// ---- core/data_store.sv ----
// small data memory with registered read data
`timescale 1ns/1ps
module data_store #(
   parameter int AW = 14,
   parameter int DW = 8
) (
   input wire logic   sys_clk,
   data_port_if.slave port
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata;

   // refuse address widths that the core cannot serve
   if (AW < 8 || AW > 16) begin : g_bad_aw
      $error("data_store: address width out of range");
   end

   // array written from a plain clocked process so that it may be preloaded from outside
   always @(posedge sys_clk) begin
      if (port.wr_en) begin
         mem[port.addr] <= port.wdata;
      end
   end

   // registered read: data reach the core one quarter after the request
   always_ff @(posedge sys_clk) begin
      if (port.rd_en) begin
         rdata <= mem[port.addr];
      end
   end

   assign port.rdata = rdata;
endmodule : data_store

// ---- core/indexed_literal_offset_exec.sv ----
// quarter-cycle executer for indexed add, bit set and fill instructions
`timescale 1ns/1ps

module indexed_literal_offset_exec #(
   parameter int AW = ilo_pkg::ADDR_W
) (
   input  wire logic          sys_clk,
   input  wire logic          nrst,
   input  wire logic          instr_valid,
   input  wire logic [15:0]   instr_word,
   input  wire logic [AW-1:0] indexed_base_pointer,
   input  wire logic          extension_enable_bit,
   input  wire logic          ext_load,
   output logic               instr_accept,
   output logic               instr_done,
   output logic               not_indexed,
   output logic [7:0]         work_reg,
   output logic [4:0]         status
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   data_port_if #(.AW(AW), .DW(ilo_pkg::DATA_W)) dport ();
   ilo_pkg::quarter_t q;
   ilo_pkg::op_kind_t kind;
   logic [15:0]       word;
   logic              ext_en;
   logic [AW-1:0]     eff_addr;
   logic [7:0]        result;
   logic [4:0]        next_status;
   logic [7:0]        next_result;
   logic              done;
   logic              reject;

   // the data store and the pointer add only serve 8 to 16 address bits
   if (AW < 8 || AW > 16) begin : g_bad_aw
      $error("indexed_literal_offset_exec: AW out of range");
   end

   data_store #(.AW(AW), .DW(ilo_pkg::DATA_W)) u_store (
      .sys_clk (sys_clk),
      .port    (dport)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode, purely combinational from the latched word
   wire       is_offset = ext_en && !word[ilo_pkg::ACCESS_BIT]
                          && (word[7:0] <= ilo_pkg::OFFSET_MAX);
   wire       dec_set   = word[15:12] == ilo_pkg::OP_SET_BIT;
   wire       dec_fill  = word[15:8] == ilo_pkg::OP_FILL;
   wire       dec_add   = word[15:10] == ilo_pkg::OP_ADD;
   wire [2:0] bit_sel   = word[ilo_pkg::BIT_SEL_LSB +: 3];
   wire       dest_mem  = word[ilo_pkg::DEST_BIT];
   wire [7:0] bit_mask  = 8'h01 << bit_sel;
   wire       idle_q1   = q == ilo_pkg::Q1;

   // accept a new word only at the start of an instruction cycle
   assign instr_accept = idle_q1;
   assign instr_done   = done;
   assign not_indexed  = reject;

   ////////////////////////////////////////////////////////////////////////////
   // add with the usual flag set
   function automatic logic [12:0] add_flags(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] sum;
      logic [4:0] lo;
      logic [4:0] st;
      sum = {1'b0, a} + {1'b0, b};
      lo  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      st  = '0;
      st[ilo_pkg::ST_C]  = sum[8];
      st[ilo_pkg::ST_DC] = lo[4];
      st[ilo_pkg::ST_Z]  = sum[7:0] == 8'h00;
      st[ilo_pkg::ST_OV] = (a[7] == b[7]) && (sum[7] != a[7]);
      st[ilo_pkg::ST_N]  = sum[7];
      return {st, sum[7:0]};
   endfunction : add_flags

   wire [12:0] add_out = add_flags(work_reg, dport.rdata);

   // fourth quarter data processing
   always_comb begin
      next_result = dport.rdata;
      next_status = status;
      case (kind)
         ilo_pkg::OPK_ADD: begin
            next_result = add_out[7:0];
            next_status = add_out[12:8];
         end
         ilo_pkg::OPK_SET:  next_result = dport.rdata | bit_mask;
         ilo_pkg::OPK_FILL: next_result = ilo_pkg::FILL_VALUE;
         default:           next_result = dport.rdata;
      endcase
   end

   // memory side: read in Q3, write in Q4
   assign dport.addr  = eff_addr;
   assign dport.rd_en = q == ilo_pkg::Q3 && kind != ilo_pkg::OPK_NONE;
   assign dport.wr_en = q == ilo_pkg::Q4 && (kind == ilo_pkg::OPK_SET || kind == ilo_pkg::OPK_FILL
                        || (kind == ilo_pkg::OPK_ADD && dest_mem));
   assign dport.wdata = result;

   ////////////////////////////////////////////////////////////////////////////
   // configuration bit, loaded when asked
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ext_en <= ilo_pkg::EXT_RESET;
      end else if (ext_load) begin
         ext_en <= extension_enable_bit;
      end
   end

   // quarter sequencer; runs only while a word is in flight
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         q <= ilo_pkg::Q1;
      end else begin
         case (q)
            ilo_pkg::Q1: q <= (instr_valid || kind != ilo_pkg::OPK_NONE) ? ilo_pkg::Q2 : ilo_pkg::Q1;
            ilo_pkg::Q2: q <= ilo_pkg::Q3;
            ilo_pkg::Q3: q <= ilo_pkg::Q4;
            ilo_pkg::Q4: q <= ilo_pkg::Q1;
            default:     q <= ilo_pkg::Q1;
         endcase
      end
   end

   // Q1 latches the word, Q2 decodes, takes the offset and forms the address
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         word     <= '0;
         kind     <= ilo_pkg::OPK_NONE;
         eff_addr <= '0;
         reject   <= 1'b0;
      end else begin
         reject <= 1'b0;
         if (idle_q1 && instr_valid) begin
            word <= instr_word;
         end
         if (q == ilo_pkg::Q2) begin
            // zero-extended offset on the full pointer, bank select ignored
            eff_addr <= indexed_base_pointer + AW'(word[7:0]);
            if (!is_offset || !(dec_add || dec_set || dec_fill)) begin
               kind   <= ilo_pkg::OPK_NONE;
               reject <= 1'b1;
            end else if (dec_add) begin
               kind <= ilo_pkg::OPK_ADD;
            end else if (dec_set) begin
               kind <= ilo_pkg::OPK_SET;
            end else begin
               kind <= ilo_pkg::OPK_FILL;
            end
         end else if (q == ilo_pkg::Q4) begin
            kind <= ilo_pkg::OPK_NONE;
         end
      end
   end

   // Q4 commits; the memory read data is valid at that quarter
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         work_reg <= '0;
         status   <= '0;
         done     <= 1'b0;
      end else begin
         done <= q == ilo_pkg::Q4;
         if (q == ilo_pkg::Q4 && kind != ilo_pkg::OPK_NONE) begin
            status <= next_status;
            if (kind == ilo_pkg::OPK_ADD && !dest_mem) begin
               work_reg <= next_result;
            end
         end
      end
   end
   assign result = next_result;
   ////////////////////////////////////////////////////////////////////////////
   // checks
   // the three quarters that follow the offset fetch, in order
   sequence s_rest_of_cycle;
      q == ilo_pkg::Q3 ##1 q == ilo_pkg::Q4 ##1 q == ilo_pkg::Q1;
   endsequence
   // a refused word must neither read in Q3 nor write in Q4
   sequence s_no_access;
      !dport.rd_en ##1 !dport.wr_en;
   endsequence

   a_fill_writes_ones: assert property (@(posedge sys_clk) disable iff (!nrst)
      dport.wr_en && kind == ilo_pkg::OPK_FILL |-> dport.wdata == ilo_pkg::FILL_VALUE)
      else $error("fill value wrong");
   a_set_keeps_flags: assert property (@(posedge sys_clk) disable iff (!nrst)
      q == ilo_pkg::Q4 && kind == ilo_pkg::OPK_SET |=> $stable(status))
      else $error("set changed flags");
   a_fill_keeps_flags: assert property (@(posedge sys_clk) disable iff (!nrst)
      q == ilo_pkg::Q4 && kind == ilo_pkg::OPK_FILL |=> $stable(status))
      else $error("fill changed flags");
   a_disabled_no_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ext_en && q == ilo_pkg::Q2 |=> s_no_access)
      else $error("access while off");
   a_quarter_order: assert property (@(posedge sys_clk) disable iff (!nrst)
      q == ilo_pkg::Q2 |=> s_rest_of_cycle)
      else $error("quarter order");
   a_done_after_q4: assert property (@(posedge sys_clk) disable iff (!nrst)
      q == ilo_pkg::Q4 |=> instr_done && q == ilo_pkg::Q1)
      else $error("done not after last quarter");
   a_address_formed: assert property (@(posedge sys_clk) disable iff (!nrst)
      q == ilo_pkg::Q2 |=> eff_addr == $past(indexed_base_pointer) + AW'($past(word[7:0])))
      else $error("bad address");
   a_high_operand_off: assert property (@(posedge sys_clk) disable iff (!nrst)
      q == ilo_pkg::Q2 && word[7:0] > ilo_pkg::OFFSET_MAX |=> kind == ilo_pkg::OPK_NONE)
      else $error("operand above 5fh");
   a_refused_untouched: assert property (@(posedge sys_clk) disable iff (!nrst)
      not_indexed |-> s_no_access ##1 ($stable(status) && $stable(work_reg)))
      else $error("refused word touched state");
   a_set_bit_mask: assert property (@(posedge sys_clk) disable iff (!nrst)
      dport.wr_en && kind == ilo_pkg::OPK_SET |-> dport.wdata[bit_sel] && $countones(dport.wdata ^ dport.rdata) <= 1)
      else $error("bit set wrong");
   a_add_to_work: assert property (@(posedge sys_clk) disable iff (!nrst)
      q == ilo_pkg::Q4 && kind == ilo_pkg::OPK_ADD && !dest_mem
      |-> !dport.wr_en ##1 work_reg == $past(add_out[7:0]))
      else $error("add result lost");
endmodule : indexed_literal_offset_exec

// ---- verification/indexed_literal_offset_exec_tb_top.sv ----
// self-checking bench for the indexed literal offset executer
`timescale 1ns/1ps
module indexed_literal_offset_exec_tb_top;
   localparam int AW = ilo_pkg::ADDR_W;
   typedef struct packed {
      logic [15:0]   word;
      logic [AW-1:0] base;
      logic [7:0]    pre;
      logic [7:0]    exp_mem;
      logic [7:0]    exp_w;
      logic [4:0]    exp_st;
      logic          exp_ni;
   } row_t;
   logic          sys_clk = 1'b0;
   logic          nrst = 1'b0;
   logic          instr_valid = 1'b0;
   logic [15:0]   instr_word = 16'h0000;
   logic [AW-1:0] indexed_base_pointer = '0;
   logic          extension_enable_bit = 1'b0;
   logic          ext_load = 1'b0;
   logic          instr_accept;
   logic          instr_done;
   logic          not_indexed;
   logic [7:0]    work_reg;
   logic [4:0]    status;
   int            bad_count = 0;
   int            n_tests = 0;
   row_t          r;
   logic [7:0]    m;
   // ordinary cases: word, base, memory before/after, work reg, flags, refused
   row_t rows [11] = '{
      '{16'h682c, 14'h0a00, 8'h00, 8'hff, 8'h00, 5'h00, 1'b0},
      '{16'h8e0a, 14'h0a00, 8'h55, 8'hd5, 8'h00, 5'h00, 1'b0},
      '{16'h2410, 14'h0a00, 8'h17, 8'h17, 8'h17, 5'h00, 1'b0},
      '{16'h242c, 14'h0a00, 8'h20, 8'h20, 8'h37, 5'h00, 1'b0},
      '{16'h2630, 14'h0a00, 8'hc9, 8'h00, 8'h37, 5'h07, 1'b0},
      '{16'h805f, 14'h0a00, 8'h00, 8'h01, 8'h37, 5'h07, 1'b0},
      '{16'h8060, 14'h0a00, 8'h3c, 8'h3c, 8'h37, 5'h07, 1'b1},
      '{16'h815f, 14'h0a00, 8'h3c, 8'h3c, 8'h37, 5'h07, 1'b1},
      '{16'h0000, 14'h0a00, 8'h3c, 8'h3c, 8'h37, 5'h07, 1'b1},
      '{16'h2440, 14'h0a00, 8'h50, 8'h50, 8'h87, 5'h18, 1'b0},
      '{16'h680f, 14'h3ff0, 8'h00, 8'hff, 8'h87, 5'h18, 1'b0}};

   indexed_literal_offset_exec #(.AW(AW)) u_dut (
      .sys_clk              (sys_clk),
      .nrst                 (nrst),
      .instr_valid          (instr_valid),
      .instr_word           (instr_word),
      .indexed_base_pointer (indexed_base_pointer),
      .extension_enable_bit (extension_enable_bit),
      .ext_load             (ext_load),
      .instr_accept         (instr_accept),
      .instr_done           (instr_done),
      .not_indexed          (not_indexed),
      .work_reg             (work_reg),
      .status               (status));

   always #5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // one instruction; base held until done since it is sampled in Q2
   task exec(input logic [15:0] w, input logic [AW-1:0] b, output logic ni, output int lat);
      int i;
      i = 0;
      while (instr_accept !== 1'b1 && i < 8) begin
         @(posedge sys_clk); #1;
         i++;
      end
      if (instr_accept !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED instr_accept expected 1 seen %b", instr_accept);
         print_verdict();
      end
      instr_word = w;
      indexed_base_pointer = b;
      instr_valid = 1'b1;
      @(posedge sys_clk); #1;
      instr_valid = 1'b0;
      ni = 1'b0;
      for (lat = 1; lat <= 8; lat++) begin
         @(posedge sys_clk); #1;
         if (lat == 1) ni = not_indexed;
         if (instr_done === 1'b1) break;
      end
      if (lat > 8) begin
         bad_count++;
         $display("CHECK FAILED instr_done expected 1 seen 0");
         print_verdict();
      end
   endtask : exec

   // preload the target byte, run, compare everything visible
   task run_row(input row_t x);
      logic          ni;
      int            lat;
      logic [AW-1:0] a;
      a = x.base + AW'(x.word[7:0]);
      u_dut.u_store.mem[a] = x.pre;
      exec(x.word, x.base, ni, lat);
      chk("latency", 16'h0003, 16'(lat));
      chk("not_indexed", {15'h0000, x.exp_ni}, {15'h0000, ni});
      chk("memory", {8'h00, x.exp_mem}, {8'h00, u_dut.u_store.mem[a]});
      chk("work_reg", {8'h00, x.exp_w}, {8'h00, work_reg});
      chk("status", {11'h000, x.exp_st}, {11'h000, status});
   endtask : run_row

   task load_ext(input logic v);
      extension_enable_bit = v;
      ext_load = 1'b1;
      @(posedge sys_clk); #1;
      ext_load = 1'b0;
   endtask : load_ext

   // outputs as a reset leaves them
   task chk_reset();
      chk("work_reg", 16'h0000, {8'h00, work_reg});
      chk("status", 16'h0000, {11'h000, status});
      chk("instr_done", 16'h0000, {15'h0000, instr_done});
      chk("not_indexed", 16'h0000, {15'h0000, not_indexed});
      chk("instr_accept", 16'h0001, {15'h0000, instr_accept});
   endtask : chk_reset

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      chk_reset();
      // enable defaults off: fill must be refused
      run_row('{16'h682c, 14'h0a00, 8'h00, 8'h00, 8'h00, 5'h00, 1'b1});
      $display("test reset done");
      load_ext(1'b1);
      // back to back table rows
      foreach (rows[i]) run_row(rows[i]);
      $display("test table done");
      // every bit select at address 3ff5, near the top of the address range
      m = 8'h00;
      for (int b = 0; b < 8; b++) begin
         r = '{{4'h8, 3'(b), 1'b0, 8'h05}, 14'h3ff0, m, m | (8'h01 << b), 8'h87, 5'h18, 1'b0};
         run_row(r);
         m = r.exp_mem;
      end
      $display("test bit selects done");
      load_ext(1'b0);
      run_row('{16'h682c, 14'h0a00, 8'h11, 8'h11, 8'h87, 5'h18, 1'b1});
      $display("test disable done");
      // reset while a fill is in flight: nothing lands and the enable falls back to off
      load_ext(1'b1);
      u_dut.u_store.mem[14'h0a2c] = 8'h22;
      instr_word = 16'h682c;
      indexed_base_pointer = 14'h0a00;
      instr_valid = 1'b1;
      @(posedge sys_clk); #1;
      instr_valid = 1'b0;
      chk("instr_accept", 16'h0000, {15'h0000, instr_accept});
      @(posedge sys_clk); #1;
      nrst = 1'b0;
      @(posedge sys_clk); #1;
      nrst = 1'b1;
      chk_reset();
      chk("memory", 16'h0022, {8'h00, u_dut.u_store.mem[14'h0a2c]});
      run_row('{16'h682c, 14'h0a00, 8'h22, 8'h22, 8'h00, 5'h00, 1'b1});
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule : indexed_literal_offset_exec_tb_top
